//--- verilog/smdusd_pkg.sv
// constants shared by both ends of the unit select and data lines
package smdusd_pkg;
  // ----------------------------------------------------------------
  // widths and bit positions
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int UNIT_W = 4;
  localparam int BUS_OUT_W = 10;
  localparam int BUS_IN_W = 8;
  localparam int CODE_W = 8;
  localparam int PRIO_BIT = 9;
  localparam int USEL_HI_BIT = 3;
  localparam int TMR_W = 16;
  localparam int POS_W = 16;
  localparam int CNT_W = 8;
  // ----------------------------------------------------------------
  // command codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RELEASE_CODE = 8'h80;
  localparam logic [15:0] RSV_TIMEOUT_DEF = 16'h03E8;
  localparam logic [15:0] REV_CYC_DEF = 16'h0800;
  localparam logic RST_LOW = 1'b0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LINK_PERIOD_PS = 32000;
  localparam int SEL_MAX_NS = 600;
  localparam int SEL_MAX_LINK_CYC = (SEL_MAX_NS * 1000) / LINK_PERIOD_PS;
  localparam int WCLK_LEAD_NS = 250;
  localparam int WCLK_LEAD_CYC = (WCLK_LEAD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int CMD_HOLD_NS = 160;
  localparam int CMD_HOLD_CYC = (CMD_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : smdusd_pkg

//--- verilog/smdusd_if.sv
// one channel of the unit select and data cable
`timescale 1ns/1ps
interface smdusd_if;
  logic sel_tag;
  logic [smdusd_pkg::UNIT_W-1:0] unit_sel;
  logic [smdusd_pkg::BUS_OUT_W-1:0] bus_out;
  logic cmd_tag;
  logic wclk_run;
  logic write_gate;
  logic write_data;
  logic [smdusd_pkg::BUS_IN_W-1:0] bus_in;
  logic busy;
  logic sel_ack;
  logic index_mark;
  logic sector_mark;
  logic read_clk;
  logic read_data;
  modport drive (
    input sel_tag, unit_sel, bus_out, cmd_tag, wclk_run, write_gate, write_data,
    output bus_in, busy, sel_ack, index_mark, sector_mark, read_clk, read_data
  );
  modport ctrl (
    output sel_tag, unit_sel, bus_out, cmd_tag, wclk_run, write_gate, write_data,
    input bus_in, busy, sel_ack, index_mark, sector_mark, read_clk, read_data
  );
endinterface : smdusd_if

//--- verilog/smdusd_ctrl.sv
// controller end of one channel: selection, commands and write stream
`timescale 1ns/1ps
module smdusd_ctrl (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic link_clk, // servo clock echoed as write clock
  smdusd_if.ctrl cab, // cable toward the drive
  input wire logic req_select, // level: keep the drive selected
  input wire logic [3:0] unit_num, // logical unit address
  input wire logic priority_sel, // level: select with priority
  input wire logic enh_tag5, // tag 5 level sent on unit bit 3 once selected
  input wire logic enhanced, // enhanced interface variant in use
  input wire logic cmd_req, // pulse: issue a command
  input wire logic [7:0] cmd_code, // command code on bus out
  output logic cmd_done, // pulse: command strobe finished
  output logic selected, // synchronised select acknowledge
  output logic busy_seen, // synchronised busy
  output logic [7:0] status, // synchronised bus in
  input wire logic wr_en, // link domain: level, request a write
  input wire logic wr_bit, // link domain: next bit to record
  output logic wr_take // link domain: pulse, wr_bit was sent
);
  // ----------------------------------------------------------------
  // system clock side
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_HIGH = 2'b01,
    C_LOW = 2'b10
  } smdusd_cst_t;
  typedef struct packed {
    logic s1_ack, s2_ack, s1_busy, s2_busy;
    logic [7:0] s1_bi, s2_bi;
    logic sel_tag;
    logic [3:0] usel;
    logic [9:0] bus_out;
    logic cmd_tag;
    smdusd_cst_t st;
    logic [smdusd_pkg::CNT_W-1:0] cnt;
    logic [7:0] code;
    logic cmd_done;
  } smdusd_cq_t;
  smdusd_cq_t q, n;
  always_comb begin
    n = q;
    n.s1_ack = cab.sel_ack;
    n.s2_ack = q.s1_ack;
    n.s1_busy = cab.busy;
    n.s2_busy = q.s1_busy;
    n.s1_bi = cab.bus_in;
    n.s2_bi = q.s1_bi;
    n.cmd_done = 1'b0;
    n.sel_tag = req_select;
    n.usel = unit_num;
    if (enhanced && q.s2_ack) n.usel[smdusd_pkg::USEL_HI_BIT] = enh_tag5;
    n.bus_out[smdusd_pkg::PRIO_BIT] = priority_sel & req_select;
    case (q.st)
      C_IDLE: begin
        n.cnt = '0;
        // commands go out only while the drive acknowledges
        if (cmd_req && q.s2_ack) begin
          n.code = cmd_code;
          n.bus_out[7:0] = cmd_code;
          n.st = C_HIGH;
        end
      end
      C_HIGH: begin
        n.cmd_tag = 1'b1;
        n.cnt = smdusd_pkg::CNT_W'(q.cnt + 1'b1);
        if (q.cnt == smdusd_pkg::CNT_W'(smdusd_pkg::CMD_HOLD_CYC - 1)) begin
          n.cmd_tag = 1'b0;
          n.cnt = '0;
          n.st = C_LOW;
        end
      end
      C_LOW: begin
        // low time lets the drive see a fresh edge for the next command
        n.cnt = smdusd_pkg::CNT_W'(q.cnt + 1'b1);
        if (q.cnt == smdusd_pkg::CNT_W'(smdusd_pkg::CMD_HOLD_CYC - 1)) begin
          n.cmd_done = 1'b1;
          n.st = C_IDLE;
        end
      end
      default: n.st = C_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (sys_rst) q <= '0;
    else q <= n;
  end
  assign cab.sel_tag = q.sel_tag;
  assign cab.unit_sel = q.usel;
  assign cab.bus_out = q.bus_out;
  assign cab.cmd_tag = q.cmd_tag;
  assign cmd_done = q.cmd_done;
  assign selected = q.s2_ack;
  assign busy_seen = q.s2_busy;
  assign status = q.s2_bi;
  // ----------------------------------------------------------------
  // link clock side: write stream
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_LEAD = 2'b01,
    W_DATA = 2'b10
  } smdusd_wst_t;
  typedef struct packed {
    logic r1, r2;
    smdusd_wst_t st;
    logic [smdusd_pkg::CNT_W-1:0] cnt;
    logic wclk_run, write_gate, write_data, wr_take;
  } smdusd_lq_t;
  smdusd_lq_t lq, ln;
  always_comb begin
    ln = lq;
    ln.wr_take = 1'b0;
    case (lq.st)
      W_IDLE: begin
        ln.write_gate = 1'b0;
        ln.wclk_run = 1'b0;
        ln.cnt = '0;
        if (wr_en) begin
          ln.wclk_run = 1'b1;
          ln.st = W_LEAD;
        end
      end
      W_LEAD: begin
        ln.cnt = smdusd_pkg::CNT_W'(lq.cnt + 1'b1);
        if (!wr_en) ln.st = W_IDLE;
        else if (lq.cnt == smdusd_pkg::CNT_W'(smdusd_pkg::WCLK_LEAD_CYC - 1)) begin
          // gate only on edges that carry a bit, so the drive records no stale cell
          ln.write_gate = 1'b1;
          ln.write_data = wr_bit;
          ln.wr_take = 1'b1;
          ln.st = W_DATA;
        end
      end
      W_DATA: begin
        if (!wr_en) begin
          ln.write_gate = 1'b0;
          ln.st = W_IDLE;
        end else begin
          ln.write_data = wr_bit;
          ln.wr_take = 1'b1;
        end
      end
      default: ln.st = W_IDLE;
    endcase
    // reset is brought into this domain by two flip-flops
    ln.r1 = sys_rst;
    ln.r2 = lq.r1;
    if (lq.r2) begin
      ln = '0;
      ln.r1 = sys_rst;
      ln.r2 = lq.r1;
    end
  end
  always_ff @(posedge link_clk) begin
    lq <= ln;
  end
  assign cab.wclk_run = lq.wclk_run;
  assign cab.write_gate = lq.write_gate;
  assign cab.write_data = lq.write_data;
  assign wr_take = lq.wr_take;
endmodule : smdusd_ctrl

//--- verilog/smdusd_drive.sv
// drive end: two-channel unit selection, reservation, marks and data lines
`timescale 1ns/1ps
module smdusd_drive #(
  parameter logic [15:0] REV_CYC = smdusd_pkg::REV_CYC_DEF // link cycles per revolution
) (
  input wire logic link_clk, // servo clock, clocks the whole drive end
  input wire logic sys_rst, // synchronous reset, active high
  smdusd_if.drive ch_a, // channel 0 cable
  smdusd_if.drive ch_b, // channel 1 cable
  input wire logic [3:0] unit_addr, // assigned logical address
  input wire logic enhanced, // enhanced interface variant switch
  input wire logic [1:0] ch_enable, // per-channel enable
  input wire logic [15:0] rsv_timeout, // reserve timeout in link cycles
  input wire logic [7:0] status_in, // status byte to present
  input wire logic index_off, // suppress index marks
  input wire logic sector_off, // suppress sector marks
  input wire logic [15:0] sectors_per_rev, // sector marks per revolution
  input wire logic disc_bit, // recovered bit from the disc
  output logic rd_take, // pulse: disc_bit taken into a cell
  output logic wr_valid, // pulse: wr_bit is a recorded bit
  output logic wr_bit, // bit to record
  output logic [1:0] sel_state, // selected per channel
  output logic [1:0] rsv_state, // reserved per channel
  output logic [1:0] tag5, // tag 5 level per channel
  output logic cmd_valid, // pulse: command accepted
  output logic cmd_chan, // channel of accepted command
  output logic [7:0] cmd_code // code of accepted command
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int NCH = smdusd_pkg::NCH;
  typedef struct packed {
    logic [NCH-1:0] s1_tag, s2_tag, s1_cmd, s2_cmd, cmd_prev;
    logic [NCH-1:0][3:0] s1_us, s2_us;
    logic [NCH-1:0][9:0] s1_bo, s2_bo;
    logic [NCH-1:0] sel, rsv, busy, tag5;
    logic [NCH-1:0][smdusd_pkg::TMR_W-1:0] tmr;
    logic [NCH-1:0][7:0] bus_in;
    logic [smdusd_pkg::POS_W-1:0] pos, acc;
    logic index_mark, sector_mark;
    logic read_clk, read_data, rd_take;
    logic wr_valid, wr_bit;
    logic cmd_valid, cmd_chan;
    logic [7:0] cmd_code;
  } smdusd_dst_t;
  smdusd_dst_t q, n;
  logic [NCH-1:0] wgate;
  logic [NCH-1:0] wdata;
  logic hit;
  logic prio;
  logic edge_cmd;
  // write lines are driven on this same clock, so they need no synchroniser
  assign wgate = {ch_b.write_gate, ch_a.write_gate};
  assign wdata = {ch_b.write_data, ch_a.write_data};
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    hit = 1'b0;
    prio = 1'b0;
    edge_cmd = 1'b0;
    // tag, address and bus lines come from the controller's clock
    n.s1_tag = {ch_b.sel_tag, ch_a.sel_tag};
    n.s2_tag = q.s1_tag;
    n.s1_us = {ch_b.unit_sel, ch_a.unit_sel};
    n.s2_us = q.s1_us;
    n.s1_bo = {ch_b.bus_out, ch_a.bus_out};
    n.s2_bo = q.s1_bo;
    n.s1_cmd = {ch_b.cmd_tag, ch_a.cmd_tag};
    n.s2_cmd = q.s1_cmd;
    n.cmd_prev = q.s2_cmd;
    n.cmd_valid = 1'b0;
    n.wr_valid = 1'b0;
    // channel 1 is evaluated last, so it wins a same-cycle priority clash
    for (int c = 0; c < NCH; c++) begin
      // reservation held without selection ages out
      if (q.rsv[c] && !q.sel[c]) begin
        if (q.tmr[c] >= rsv_timeout) begin
          n.rsv[c] = 1'b0;
          n.tmr[c] = '0;
        end else begin
          n.tmr[c] = smdusd_pkg::TMR_W'(q.tmr[c] + 1'b1);
        end
      end
      // bit 3 joins the compare until selected under the enhanced variant
      hit = (q.s2_us[c][2:0] == unit_addr[2:0]) &&
            ((q.s2_us[c][smdusd_pkg::USEL_HI_BIT] == unit_addr[3]) ||
             (enhanced && q.sel[c]));
      prio = q.s2_bo[c][smdusd_pkg::PRIO_BIT];
      n.busy[c] = q.busy[c] & q.s2_tag[c];
      if (!q.s2_tag[c]) begin
        n.sel[c] = 1'b0;
      // a held selection is not re-reserved each cycle, so a release sticks
      end else if (hit && ch_enable[c] && !q.sel[c]) begin
        if (prio) begin
          n.sel[c] = 1'b1;
          n.rsv[c] = 1'b1;
          n.busy[c] = 1'b0;
          n.tmr[c] = '0;
          n.sel[c ^ 1] = 1'b0;
          n.rsv[c ^ 1] = 1'b0;
        end else if (!q.sel[c] && (n.sel[c ^ 1] || n.rsv[c ^ 1])) begin
          n.busy[c] = 1'b1;
        end else begin
          n.sel[c] = 1'b1;
          n.rsv[c] = 1'b1;
          n.tmr[c] = '0;
        end
      end
      n.tag5[c] = enhanced & n.sel[c] & q.s2_us[c][smdusd_pkg::USEL_HI_BIT];
      // commands count only on a fresh strobe while acknowledged
      edge_cmd = q.s2_cmd[c] & ~q.cmd_prev[c];
      if (edge_cmd && q.sel[c]) begin
        n.cmd_valid = 1'b1;
        n.cmd_chan = c[0];
        n.cmd_code = q.s2_bo[c][7:0];
        n.tmr[c] = '0;
        if (q.s2_bo[c][7:0] == smdusd_pkg::RELEASE_CODE) n.rsv[c] = 1'b0;
      end
      n.bus_in[c] = n.sel[c] ? status_in : '0;
      if (q.sel[c] && wgate[c]) begin
        n.wr_valid = 1'b1;
        n.wr_bit = wdata[c];
      end
    end
    // ----------------------------------------------------------------
    // revolution position, index and sector marks
    // ----------------------------------------------------------------
    n.index_mark = 1'b0;
    n.sector_mark = 1'b0;
    if (q.pos >= REV_CYC - 16'h0001) begin
      n.pos = '0;
      n.acc = '0;
      n.index_mark = ~index_off;
      n.sector_mark = ~sector_off;
    end else begin
      n.pos = smdusd_pkg::POS_W'(q.pos + 1'b1);
      // even spread: one mark each time the sum passes a revolution
      n.acc = smdusd_pkg::POS_W'(q.acc + sectors_per_rev);
      if (n.acc >= REV_CYC) begin
        n.acc = smdusd_pkg::POS_W'(n.acc - REV_CYC);
        n.sector_mark = ~sector_off;
      end
    end
    // ----------------------------------------------------------------
    // read clock and data: one cell per two link cycles
    // ----------------------------------------------------------------
    n.read_clk = ~q.read_clk;
    n.rd_take = 1'b0;
    if (!q.read_clk) begin
      n.read_data = disc_bit;
      n.rd_take = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (sys_rst) q <= '0;
    else q <= n;
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ch_a.bus_in = q.bus_in[0];
  assign ch_b.bus_in = q.bus_in[1];
  assign ch_a.busy = q.busy[0];
  assign ch_b.busy = q.busy[1];
  assign ch_a.sel_ack = q.sel[0];
  assign ch_b.sel_ack = q.sel[1];
  assign ch_a.index_mark = q.index_mark;
  assign ch_b.index_mark = q.index_mark;
  assign ch_a.sector_mark = q.sector_mark;
  assign ch_b.sector_mark = q.sector_mark;
  assign ch_a.read_clk = q.read_clk;
  assign ch_b.read_clk = q.read_clk;
  assign ch_a.read_data = q.read_data;
  assign ch_b.read_data = q.read_data;
  assign rd_take = q.rd_take;
  assign wr_valid = q.wr_valid;
  assign wr_bit = q.wr_bit;
  assign sel_state = q.sel;
  assign rsv_state = q.rsv;
  assign tag5 = q.tag5;
  assign cmd_valid = q.cmd_valid;
  assign cmd_chan = q.cmd_chan;
  assign cmd_code = q.cmd_code;
endmodule : smdusd_drive

//--- sim/smdusd_chk.sv
// concurrent checks on channel 0 of the unit select and data cable
`timescale 1ns/1ps
module smdusd_chk #(
  parameter int REV_CYC = 64, // link cycles per revolution
  parameter logic [3:0] UNIT = 4'hA // address the drive answers to
) (
  input wire logic link_clk, // servo clock
  input wire logic sys_rst, // sync reset, high
  input wire logic sel_tag, // unit select tag
  input wire logic [3:0] unit_sel, // unit number
  input wire logic wclk_run, // write clock echoed
  input wire logic write_gate, // write gate
  input wire logic write_data, // nrz write bit
  input wire logic [7:0] bus_in, // status byte
  input wire logic busy, // busy to this channel
  input wire logic sel_ack, // select acknowledge
  input wire logic index_mark, // index pulse
  input wire logic read_clk, // read clock
  input wire logic read_data // nrz read bit
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lo_cnt;
    logic [15:0] gap;
    logic seen;
  } smdusd_chk_t;
  smdusd_chk_t st;
  smdusd_chk_t next_st;
  always_comb begin
    next_st = st;
    if (sel_tag) next_st.lo_cnt = 8'h00;
    else if (st.lo_cnt != 8'hFF) next_st.lo_cnt = st.lo_cnt + 8'h01;
    next_st.gap = index_mark ? 16'h0000 : st.gap + 16'h0001;
    if (index_mark) next_st.seen = 1'b1;
    if (sys_rst) next_st = '0;
  end
  always_ff @(posedge link_clk) st <= next_st;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (sys_rst);
  AST_SEL_TIME: assert property (
    $rose(sel_tag) && unit_sel == UNIT |-> ##[1:18] (sel_ack || busy))
    else $error("select not answered in time");
  AST_DESEL_TIME: assert property (
    $fell(sel_tag) |-> ##[1:18] !sel_ack) else $error("deselect too slow");
  AST_ACK_NEEDS_TAG: assert property (
    sel_ack |-> st.lo_cnt <= 8'h13) else $error("acknowledge without tag");
  AST_BUSIN_IDLE: assert property (
    !sel_ack |-> bus_in == 8'h00) else $error("status while not selected");
  AST_BUSY_UNSEL: assert property (
    busy |-> !sel_ack) else $error("busy to the selecting channel");
  AST_BUSY_CLEAR: assert property (
    $fell(sel_tag) |-> ##[1:18] !busy) else $error("busy outlives tag");
  AST_INDEX_REV: assert property (
    index_mark && st.seen |-> ((st.gap + 16'h0001) % REV_CYC) == 0)
    else $error("index not once per revolution");
  AST_WGATE_LEAD: assert property (
    $rose(write_gate) |-> wclk_run && $past(wclk_run, 8)) else $error("gate before clock lead");
  AST_WDATA_IN_GATE: assert property (
    $changed(write_data) |-> write_gate || $past(write_gate))
    else $error("write data moves outside gate");
  AST_RDATA_CELL: assert property (
    $changed(read_data) |-> $rose(read_clk)) else $error("read data off cell start");
endmodule : smdusd_chk

//--- sim/test_smd_unit_select_and_data_lines.sv
// self-checking bench: two controllers facing one two-channel drive
`timescale 1ns/1ps
module test_smd_unit_select_and_data_lines;
  localparam int REV = 64;
  localparam logic [3:0] UNIT = 4'hA;
  logic clock, link_clk, sys_rst, enh, index_off, sector_off, disc_bit, wa_s, disc_s;
  logic [1:0] req, pri, enh5, creq, wen, wbit, ch_en;
  logic [3:0] unum [2];
  logic [7:0] code [2];
  logic [7:0] st_in;
  logic [31:0] rnd;
  wire [1:0] done, seln, busyv, wtake, sel_st, rsv_st, tag5;
  wire [7:0] stat [2];
  wire [7:0] cmd_code_o;
  wire rd_take, wr_valid, wr_bit_o, cmd_valid, cmd_chan;
  int error_cnt, n_checks, m_sel, m_rsv, m_busy, n_idx, n_sec, n_wr;
  int cq[$];
  logic wq[$];
  smdusd_if cab[2]();
  for (genvar g = 0; g < 2; g++) begin : g_ch
    smdusd_ctrl u_smdusd_ctrl (
      .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk), .cab(cab[g]),
      .req_select(req[g]), .unit_num(unum[g]), .priority_sel(pri[g]), .enh_tag5(enh5[g]),
      .enhanced(enh), .cmd_req(creq[g]), .cmd_code(code[g]), .cmd_done(done[g]),
      .selected(seln[g]), .busy_seen(busyv[g]), .status(stat[g]), .wr_en(wen[g]),
      .wr_bit(wbit[g]), .wr_take(wtake[g]));
  end
  smdusd_drive #(.REV_CYC(16'h0040)) u_smdusd_drive (
    .link_clk(link_clk), .sys_rst(sys_rst), .ch_a(cab[0]), .ch_b(cab[1]), .unit_addr(UNIT),
    .enhanced(enh), .ch_enable(ch_en), .rsv_timeout(16'h0032), .status_in(st_in),
    .index_off(index_off), .sector_off(sector_off), .sectors_per_rev(16'h0008),
    .disc_bit(disc_bit), .rd_take(rd_take), .wr_valid(wr_valid), .wr_bit(wr_bit_o),
    .sel_state(sel_st), .rsv_state(rsv_st), .tag5(tag5), .cmd_valid(cmd_valid),
    .cmd_chan(cmd_chan), .cmd_code(cmd_code_o));
  smdusd_chk #(.REV_CYC(REV), .UNIT(UNIT)) u_smdusd_chk (
    .link_clk(link_clk), .sys_rst(sys_rst), .sel_tag(cab[0].sel_tag),
    .unit_sel(cab[0].unit_sel), .wclk_run(cab[0].wclk_run), .write_gate(cab[0].write_gate),
    .write_data(cab[0].write_data), .bus_in(cab[0].bus_in), .busy(cab[0].busy),
    .sel_ack(cab[0].sel_ack), .index_mark(cab[0].index_mark), .read_clk(cab[0].read_clk),
    .read_data(cab[0].read_data));
  // ----------------------------------------------------------------
  // clocks and monitors
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    wa_s = wbit[0];
    disc_s = disc_bit;
  end
  always @(negedge link_clk) begin
    if (!sys_rst) begin
      if (wtake[0] === 1'b1) wq.push_back(wa_s);
      if (wr_valid === 1'b1) begin
        n_wr++;
        chk({15'h0, wr_bit_o}, {15'h0, wq.size() > 0 ? wq.pop_front() : ~wr_bit_o});
      end
      if (rd_take === 1'b1 && sel_st[0] === 1'b1) begin
        chk({15'h0, cab[0].read_data}, {15'h0, disc_s});
      end
      if (cmd_valid === 1'b1) begin
        chk({7'h0, cmd_chan, cmd_code_o}, cq.size() ? 16'(cq.pop_front()) : 16'hFFFF);
      end
      if (cab[0].index_mark === 1'b1) n_idx++;
      if (cab[0].sector_mark === 1'b1) n_sec++;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cw(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cw
  task automatic lw(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : lw
  // selection settles well inside 24 link cycles plus the controller's syncs
  task automatic sel(input int ch, input logic [3:0] u, input logic p, input logic v);
    cw(1);
    unum[ch] = u;
    pri[ch] = p;
    req[ch] = v;
    lw(24);
  endtask : sel
  task automatic cmd(input int ch, input logic [7:0] c);
    int i;
    cw(1);
    code[ch] = c;
    creq[ch] = 1'b1;
    cq.push_back(ch * 256 + c);
    cw(1);
    creq[ch] = 1'b0;
    for (i = 0; i < 200 && done[ch] !== 1'b1; i++) cw(1);
    chk({15'h0, done[ch]}, 16'h0001);
  endtask : cmd
  task automatic cmp_state;
    int c;
    for (c = 0; c < 2; c++) begin
      chk({8'h00, stat[c]}, m_sel[c] ? {8'h00, st_in} : 16'h0000);
      chk({15'h0, seln[c]}, 16'(m_sel[c]));
      chk({15'h0, busyv[c]}, 16'(m_busy[c]));
    end
    chk({12'h0, rsv_st, sel_st}, 16'(m_rsv * 4 + m_sel));
  endtask : cmp_state
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    int i;
    int k;
    {req, pri, enh5, creq, wen, wbit} = '0;
    {enh, index_off, sector_off, disc_bit} = '0;
    unum = '{UNIT, UNIT};
    code = '{8'h00, 8'h00};
    ch_en = 2'b11;
    rnd = lfsr(32'h8fdf);
    st_in = rnd[7:0];
    sys_rst = 1'b1;
    // held in link cycles so the drive and both synchronisers see enough edges
    lw(12);
    sys_rst = 1'b0;
    cw(2);
    for (i = 0; i < 4; i++) begin
      sel(0, UNIT ^ 4'(1 << i), 1'b0, 1'b1);
      cmp_state();
      sel(0, UNIT, 1'b0, 1'b0);
    end
    sel(0, UNIT, 1'b0, 1'b1);
    m_sel = 1;
    m_rsv = 1;
    cmp_state();
    sel(1, UNIT, 1'b0, 1'b1);
    m_busy = 2;
    cmp_state();
    sel(1, UNIT, 1'b0, 1'b0);
    m_busy = 0;
    cmp_state();
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      cmd(0, {1'b0, rnd[6:0]});
    end
    cmd(0, smdusd_pkg::RELEASE_CODE);
    m_rsv = 0;
    cmp_state();
    sel(0, UNIT, 1'b0, 1'b0);
    m_sel = 0;
    cmp_state();
    sel(1, UNIT, 1'b0, 1'b1);
    m_sel = 2;
    m_rsv = 2;
    cmp_state();
    sel(0, UNIT, 1'b1, 1'b1);
    m_sel = 1;
    m_rsv = 1;
    chk({12'h0, rsv_st, sel_st}, 16'h0005);
    m_busy = 2;
    cmp_state();
    sel(1, UNIT, 1'b0, 1'b0);
    m_busy = 0;
    cmp_state();
    // tag 5 low first, so a drive still comparing bit 3 would drop out
    for (k = 0; k < 2; k++) begin
      cw(1);
      enh = 1'b1;
      enh5[0] = k[0];
      lw(24);
      chk({14'h0, tag5}, 16'(k));
      cmp_state();
    end
    lw(1);
    wen[0] = 1'b1;
    for (i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      wbit[0] = rnd[0];
      disc_bit = rnd[1];
      lw(1);
    end
    wen[0] = 1'b0;
    lw(6);
    chk(16'(wq.size()), 16'h0000);
    chk({15'h0, n_wr > 20}, 16'h0001);
    sel(0, UNIT, 1'b0, 1'b0);
    m_sel = 0;
    cmp_state();
    lw(50);
    m_rsv = 0;
    cmp_state();
    cw(1);
    enh = 1'b0;
    ch_en = 2'b01;
    sel(1, UNIT, 1'b1, 1'b1);
    cmp_state();
    sel(1, UNIT, 1'b0, 1'b0);
    for (k = 0; k < 4; k++) begin
      lw(1);
      {index_off, sector_off} = 2'(k);
      lw(4);
      n_idx = 0;
      n_sec = 0;
      lw(REV * 3);
      chk(16'(n_idx), k[1] ? 16'h0000 : 16'h0003);
      chk(16'(n_sec), k[0] ? 16'h0000 : 16'h0018);
    end
    tally_and_finish();
  end
endmodule : test_smd_unit_select_and_data_lines
